// file: dv/lp_model.sv
`timescale 1ns/10ps
module lp_model
	import an_cw_pkg::*;
(
	input wire logic clk,
	output rx_page_t rx_page
);
	// ------------------------------------------------------------
	// Link partner base pages
	// ------------------------------------------------------------
	// Between pages the code word is not held.
	// The inverse of the last page shows up any late sampling.
	initial rx_page = '0;

	task automatic send_page(input logic [15:0] w, input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		rx_page.code_word <= w;
		rx_page.page_valid <= 1'b1;
		@(posedge clk);
		rx_page.page_valid <= 1'b0;
		rx_page.code_word <= ~w;
	endtask

	task automatic drop_link();
		@(posedge clk);
		rx_page.link_down <= 1'b1;
		@(posedge clk);
		rx_page.link_down <= 1'b0;
	endtask
endmodule

// file: dv/tb_fiber_autoneg_codeword_regs.sv
`timescale 1ns/10ps
module tb_fiber_autoneg_codeword_regs
	import an_cw_pkg::*;
;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [1:0] media_mode = MODE_SGMII_MEDIA;
	logic pause_en = 1'b0;
	copper_status_t cs = '0;
	rx_page_t rx_page;
	logic [REG_ADDR_W-1:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] rdata;
	logic waitreq;
	logic [1:0] resp;
	logic [DATA_W-1:0] got;
	logic [1:0] got_resp;
	logic [15:0] w;
	int n_fail = 0;
	int num_checks = 0;
	int seed = 55;
	int exp_word;

	always #25 clk = ~clk;

	fiber_autoneg_codeword_regs fiber_autoneg_codeword_regs_inst (.clk(clk), .arst_n(arst_n),
		.clk_en(1'b1), .media_mode(media_mode), .pause_media_report_en(pause_en),
		.copper_status(cs), .rx_page(rx_page), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
		.avs_waitrequest(waitreq), .avs_response(resp));

	lp_model lp_model_inst (.clk(clk), .rx_page(rx_page));

	// ------------------------------------------------------------
	// Bus and result tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Waitrequest is combinational, so it is judged between edges where it is settled;
	// the rising edge after a low sample answers, and data is taken there.
	task automatic bus(input logic is_wr, input logic [3:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		rd <= ~is_wr;
		wr <= is_wr;
		addr <= a;
		wdata <= d;
		@(negedge clk);
		while (waitreq !== 1'b0) begin
			if (t >= 50) begin
				n_fail++;
				print_verdict();
			end
			@(negedge clk);
			t++;
		end
		@(posedge clk);
		got = rdata;
		got_resp = resp;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	function automatic logic [31:0] adv_exp();
		return {16'h0, cs.link_up, 2'b00, cs.full_duplex, cs.speed, pause_en & cs.tx_pause,
			pause_en & cs.rx_pause, pause_en & cs.fiber_media, 7'h01};
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		bus(1'b1, ADDR_ADVERT, 32'hffff_fffe);
		bus(1'b0, ADDR_ADVERT, 32'h0);
		check("media advert", 32'h0000_0001, got);
		bus(1'b0, ADDR_PARTNER, 32'h0);
		check("partner after reset", 32'h0, got);
		media_mode <= MODE_SGMII_SYS;
		for (int i = 0; i < 24; i++) begin
			cs <= copper_status_t'($random(seed));
			pause_en <= 1'($random(seed));
			bus(1'b1, ADDR_ADVERT, $random(seed));
			bus(1'b0, ADDR_ADVERT, 32'h0);
			check("system advert", adv_exp(), got);
		end
		media_mode <= MODE_1000BASEX;
		for (int i = 0; i < 16; i++) begin
			w = 16'($random(seed)) & 16'hffe0;
			lp_model_inst.send_page(w, i % 4);
			exp_word = w;
			bus(1'b1, ADDR_PARTNER, {16'h0, ~w});
			bus(1'b0, ADDR_PARTNER, 32'h0);
			check("1000basex partner", 32'(exp_word), got);
			if (i % 4 == 3) begin
				lp_model_inst.drop_link();
				exp_word = 0;
				bus(1'b0, ADDR_PARTNER, 32'h0);
				check("partner on loss", 32'(exp_word), got);
			end
		end
		lp_model_inst.send_page(16'h5a40, 0);
		@(posedge clk);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		bus(1'b0, ADDR_PARTNER, 32'h0);
		check("partner after mid reset", 32'h0, got);
		media_mode <= 2'h0;
		bus(1'b0, ADDR_ADVERT, 32'h0);
		check("mode 00 advert", 32'h0, got);
		media_mode <= MODE_SGMII_SYS;
		lp_model_inst.drop_link();
		for (int i = 0; i < 5; i++) begin
			w = {1'b0, i[0], 14'h0001};
			lp_model_inst.send_page(w, 0);
			exp_word = i[0] ? 32'h4000 : 0;
			if (i == 4) begin
				lp_model_inst.drop_link();
				exp_word = 0;
			end
			bus(1'b0, ADDR_PARTNER, 32'h0);
			check("system partner", 32'(exp_word), got);
		end
		bus(1'b0, 4'h9, 32'h0);
		check("unmapped response", 32'h2, {30'h0, got_resp});
		check("unmapped data", 32'h0, got);
		print_verdict();
	end
endmodule

// file: src/an_cw_pkg.sv
package an_cw_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_ADVERT = 4'h4;
	localparam logic [3:0] ADDR_PARTNER = 4'h5;
	localparam int REG_ADDR_W = 4;
	localparam int DATA_W = 32;

	// ----------------------------------------------------------------
	// Media mode field values
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_1000BASEX = 2'h1;
	localparam logic [1:0] MODE_SGMII_SYS = 2'h2;
	localparam logic [1:0] MODE_SGMII_MEDIA = 2'h3;

	// ----------------------------------------------------------------
	// Field positions and constants
	// ----------------------------------------------------------------
	localparam int BIT_LINK = 15;
	localparam int BIT_ACK = 14;
	localparam int BIT_DUPLEX = 12;
	localparam int BIT_TX_PAUSE = 9;
	localparam int BIT_RX_PAUSE = 8;
	localparam int BIT_MEDIA = 7;
	localparam logic [6:0] ADV_LOW_BITS = 7'h01;
	localparam logic [15:0] MEDIA_ADVERT_VALUE = 16'h0001;
	localparam logic [15:0] PARTNER_RESET = 16'h0000;
	localparam int READ_LATENCY = 1;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic link_up;
		logic full_duplex;
		logic [1:0] speed;
		logic tx_pause;
		logic rx_pause;
		logic fiber_media;
	} copper_status_t;

	typedef struct packed {
		logic [15:0] code_word;
		logic page_valid;
		logic link_down;
	} rx_page_t;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_t;

endpackage

// file: src/fiber_autoneg_codeword_regs.sv
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
module fiber_autoneg_codeword_regs
	import an_cw_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [1:0] media_mode,
	input wire logic pause_media_report_en,
	input wire copper_status_t copper_status,
	input wire rx_page_t rx_page,
	input wire logic [REG_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		bus_state_t bus;
		logic [DATA_W-1:0] rdata;
		logic [1:0] resp;
	} top_state_t;

	top_state_t state_reg;
	top_state_t state_next;
	logic [15:0] partner_word;
	logic [15:0] advert_word;
	logic [15:0] load_mask;
	logic partner_load;
	logic partner_clear;

	// ----------------------------------------------------------------
	// Advertisement view
	// ----------------------------------------------------------------
	function automatic logic [15:0] sys_advert(input copper_status_t s, input logic en);
		logic [15:0] w;
		w = 16'h0000;
		w[BIT_LINK] = s.link_up;
		w[BIT_DUPLEX] = s.full_duplex;
		w[11:10] = s.speed;
		w[BIT_TX_PAUSE] = s.tx_pause & en;
		w[BIT_RX_PAUSE] = s.rx_pause & en;
		w[BIT_MEDIA] = s.fiber_media & en;
		w[6:0] = ADV_LOW_BITS;
		return w;
	endfunction

	always_comb begin
		case (media_mode)
			MODE_SGMII_SYS: advert_word = sys_advert(copper_status, pause_media_report_en);
			MODE_SGMII_MEDIA: advert_word = MEDIA_ADVERT_VALUE;
			default: advert_word = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Partner ability capture
	// ----------------------------------------------------------------
	// The layout follows the mode: all bits in 1000BASE-X, acknowledge only in system mode.
	always_comb begin
		case (media_mode)
			MODE_1000BASEX: load_mask = 16'hffff;
			MODE_SGMII_SYS: load_mask = 16'h4000;
			default: load_mask = 16'h0000;
		endcase
	end

	assign partner_clear = rx_page.link_down;
	// Only the two documented layouts capture; other modes must leave the word untouched.
	assign partner_load = rx_page.page_valid && (load_mask != 16'h0000);

	partner_capture #(
		.WIDTH(16)
	) u_capture (
		.clk(clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.clear(partner_clear),
		.load(partner_load),
		.load_mask(load_mask),
		.load_data(rx_page.code_word),
		.q(partner_word)
	);

	// ----------------------------------------------------------------
	// Avalon-MM slave
	// ----------------------------------------------------------------
	// Every access stalls exactly one cycle; writes are acknowledged but change nothing.
	always_comb begin
		state_next = state_reg;
		case (state_reg.bus)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					state_next.bus = BUS_ANSWER;
					state_next.rdata = '0;
					state_next.resp = 2'h0;
					if (avs_read) begin
						case (avs_address)
							ADDR_ADVERT: state_next.rdata = {16'h0000, advert_word};
							ADDR_PARTNER: state_next.rdata = {16'h0000, partner_word};
							default: state_next.resp = 2'h2;
						endcase
					end else if (avs_address != ADDR_ADVERT && avs_address != ADDR_PARTNER) begin
						state_next.resp = 2'h2;
					end
				end
			end
			BUS_ANSWER: begin
				state_next.bus = BUS_IDLE;
			end
			default: begin
				state_next.bus = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '{bus: BUS_IDLE, rdata: '0, resp: 2'h0};
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && (state_reg.bus != BUS_ANSWER);
	assign avs_readdata = state_reg.rdata;
	assign avs_response = state_reg.resp;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_link_bit;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == MODE_SGMII_SYS) |-> advert_word[BIT_LINK] == copper_status.link_up;
	endproperty
	a_link_bit: assert property (p_link_bit) else $error("link bit wrong");

	property p_speed_duplex;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == MODE_SGMII_SYS) |->
			advert_word[12:10] == {copper_status.full_duplex, copper_status.speed};
	endproperty
	a_speed_duplex: assert property (p_speed_duplex) else $error("speed or duplex wrong");

	property p_pause_forced;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == MODE_SGMII_SYS && !pause_media_report_en) |-> advert_word[9:7] == 3'h0;
	endproperty
	a_pause_forced: assert property (p_pause_forced) else $error("pause not forced");

	property p_sys_const;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == MODE_SGMII_SYS) |->
			advert_word[14:13] == 2'h0 && advert_word[6:0] == ADV_LOW_BITS;
	endproperty
	a_sys_const: assert property (p_sys_const) else $error("fixed bits wrong");

	property p_media_const;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == MODE_SGMII_MEDIA) |-> advert_word == MEDIA_ADVERT_VALUE;
	endproperty
	a_media_const: assert property (p_media_const) else $error("media advert not 0x0001");

	property p_clear_on_loss;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && rx_page.link_down) |=> partner_word == 16'h0000;
	endproperty
	a_clear_on_loss: assert property (p_clear_on_loss) else $error("partner not cleared");

	property p_load_basex;
		logic [15:0] cw;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && rx_page.page_valid && !rx_page.link_down && media_mode == MODE_1000BASEX,
			cw = rx_page.code_word) |=> partner_word == cw;
	endproperty
	a_load_basex: assert property (p_load_basex) else $error("page not captured");

	property p_sys_ack_only;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && rx_page.page_valid && !rx_page.link_down && media_mode == MODE_SGMII_SYS) |=>
			partner_word == {1'b0, $past(rx_page.code_word[BIT_ACK]), 14'h0000};
	endproperty
	a_sys_ack_only: assert property (p_sys_ack_only) else $error("system capture wrong");

	property p_write_ignored;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && avs_write && !rx_page.page_valid && !rx_page.link_down) |=> $stable(partner_word);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write altered partner");

	property p_one_wait;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && avs_read && state_reg.bus == BUS_IDLE) |-> avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("no wait on first cycle");

	logic page_basex;
	assign page_basex = clk_en && rx_page.page_valid && !rx_page.link_down &&
		media_mode == MODE_1000BASEX;

	property p_duplex_bit;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == MODE_SGMII_SYS) |-> advert_word[BIT_DUPLEX] == copper_status.full_duplex;
	endproperty
	a_duplex_bit: assert property (p_duplex_bit) else $error("duplex bit wrong");

	property p_speed_code;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == MODE_SGMII_SYS) |-> advert_word[11:10] == copper_status.speed;
	endproperty
	a_speed_code: assert property (p_speed_code) else $error("speed code wrong");

	property p_tx_pause;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == MODE_SGMII_SYS && pause_media_report_en) |-> advert_word[9] == copper_status.tx_pause;
	endproperty
	a_tx_pause: assert property (p_tx_pause) else $error("transmit pause wrong");

	property p_rx_pause;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == MODE_SGMII_SYS && pause_media_report_en) |-> advert_word[8] == copper_status.rx_pause;
	endproperty
	a_rx_pause: assert property (p_rx_pause) else $error("receive pause wrong");

	property p_media_type;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == MODE_SGMII_SYS && pause_media_report_en) |-> advert_word[7] == copper_status.fiber_media;
	endproperty
	a_media_type: assert property (p_media_type) else $error("media type bit wrong");

	property p_other_mode_advert;
		@(posedge clk) disable iff (!arst_n)
		(media_mode == 2'h0) |-> advert_word == 16'h0000;
	endproperty
	a_other_mode_advert: assert property (p_other_mode_advert) else $error("mode 00 advert");

	property p_next_page_bit;
		@(posedge clk) disable iff (!arst_n)
		page_basex |=> partner_word[15] == $past(rx_page.code_word[15]);
	endproperty
	a_next_page_bit: assert property (p_next_page_bit) else $error("next page bit wrong");

	property p_ack_bit;
		@(posedge clk) disable iff (!arst_n)
		page_basex |=> partner_word[14] == $past(rx_page.code_word[14]);
	endproperty
	a_ack_bit: assert property (p_ack_bit) else $error("acknowledge bit wrong");

	property p_fault_code;
		@(posedge clk) disable iff (!arst_n)
		page_basex |=> partner_word[13:12] == $past(rx_page.code_word[13:12]);
	endproperty
	a_fault_code: assert property (p_fault_code) else $error("remote fault wrong");

	property p_pause_code;
		@(posedge clk) disable iff (!arst_n)
		page_basex |=> partner_word[8:7] == $past(rx_page.code_word[8:7]);
	endproperty
	a_pause_code: assert property (p_pause_code) else $error("pause code wrong");

	property p_half_bit;
		@(posedge clk) disable iff (!arst_n)
		page_basex |=> partner_word[6] == $past(rx_page.code_word[6]);
	endproperty
	a_half_bit: assert property (p_half_bit) else $error("half duplex bit wrong");

	property p_full_bit;
		@(posedge clk) disable iff (!arst_n)
		page_basex |=> partner_word[5] == $past(rx_page.code_word[5]);
	endproperty
	a_full_bit: assert property (p_full_bit) else $error("full duplex bit wrong");

	property p_reserved_capture;
		@(posedge clk) disable iff (!arst_n)
		page_basex |=> partner_word[11:9] == $past(rx_page.code_word[11:9]);
	endproperty
	a_reserved_capture: assert property (p_reserved_capture) else $error("bits 11:9 wrong");

	property p_low_capture;
		@(posedge clk) disable iff (!arst_n)
		page_basex |=> partner_word[4:0] == $past(rx_page.code_word[4:0]);
	endproperty
	a_low_capture: assert property (p_low_capture) else $error("bits 4:0 wrong");

	property p_hold_between;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && !rx_page.page_valid && !rx_page.link_down) |=> $stable(partner_word);
	endproperty
	a_hold_between: assert property (p_hold_between) else $error("partner word drifted");

	property p_no_capture_other;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && rx_page.page_valid && !rx_page.link_down && media_mode != MODE_1000BASEX &&
			media_mode != MODE_SGMII_SYS) |=> $stable(partner_word);
	endproperty
	a_no_capture_other: assert property (p_no_capture_other) else $error("captured in other mode");

	property p_read_advert;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && avs_read && state_reg.bus == BUS_IDLE && avs_address == ADDR_ADVERT) |=>
			avs_readdata == {16'h0000, $past(advert_word)};
	endproperty
	a_read_advert: assert property (p_read_advert) else $error("advert read data wrong");

	property p_read_partner;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && avs_read && state_reg.bus == BUS_IDLE && avs_address == ADDR_PARTNER) |=>
			avs_readdata == {16'h0000, $past(partner_word)};
	endproperty
	a_read_partner: assert property (p_read_partner) else $error("partner read data wrong");

	property p_upper_zero;
		@(posedge clk) disable iff (!arst_n)
		avs_readdata[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

	property p_unmapped_err;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && (avs_read || avs_write) && state_reg.bus == BUS_IDLE &&
			avs_address != ADDR_ADVERT && avs_address != ADDR_PARTNER) |=> avs_response == 2'h2;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped not refused");

	property p_answer_once;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && state_reg.bus == BUS_ANSWER) |=> state_reg.bus == BUS_IDLE;
	endproperty
	a_answer_once: assert property (p_answer_once) else $error("answer held too long");

endmodule

// file: src/partner_capture.sv
`timescale 1ns/10ps
module partner_capture
	import an_cw_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_mask,
	input wire logic [WIDTH-1:0] load_data,
	output logic [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] word;
	} cap_state_t;

	cap_state_t state_reg;
	cap_state_t state_next;

	initial begin
		if (WIDTH != 16) begin
			$error("partner_capture supports only a 16-bit word");
		end
	end

	// Link loss outranks a page arriving in the same cycle, so a stale page never survives.
	always_comb begin
		state_next = state_reg;
		if (clear) begin
			state_next.word = '0;
		end else if (load) begin
			state_next.word = load_data & load_mask;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '0;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	assign q = state_reg.word;

endmodule
